// ### hw/pcc_pkg.sv
package pcc_pkg;

   // ==========================================================
   // Mode register bit positions
   localparam int MODE_IRQ_EN_BIT   = 0;
   localparam int MODE_PULSE_BIT    = 1;
   localparam int MODE_TOGGLE_BIT   = 2;
   localparam int MODE_MATCH_BIT    = 3;
   localparam int MODE_FALL_BIT     = 4;
   localparam int MODE_RISE_BIT     = 5;
   localparam int MODE_CMP_EN_BIT   = 6;
   localparam int MODE_WIDE_BIT     = 7;

   // ==========================================================
   // Shared configuration bit positions
   localparam int CFG_CLEN_LSB      = 0;
   localparam int CFG_MID_FLAG_BIT  = 4;
   localparam int CFG_MID_IRQ_BIT   = 5;
   localparam int CFG_RELOAD_BIT    = 7;

   // ==========================================================
   // Reset values, frequency zero step and synchroniser depth
   localparam logic [7:0]  MODE_RESET = 8'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [7:0]  FREQ_ZERO_STEP = 8'h00;
   localparam int          SYNC_STAGES = 3;

   // ==========================================================
   // Register selector on the byte port
   typedef enum logic [1:0]
   {
      PCC_SEL_MODE  = 2'b00,
      PCC_SEL_LOW   = 2'b01,
      PCC_SEL_HIGH  = 2'b10,
      PCC_SEL_NONE  = 2'b11
   } pcc_sel_e;

   // Decoded operating mode
   typedef enum logic [2:0]
   {
      PCC_M_IDLE    = 3'b000,
      PCC_M_CAPTURE = 3'b001,
      PCC_M_TIMER   = 3'b010,
      PCC_M_TOGGLE  = 3'b011,
      PCC_M_FREQ    = 3'b100,
      PCC_M_PWM_N   = 3'b101,
      PCC_M_PWM_16  = 3'b110
   } pcc_mode_e;

   // Byte register access from the processor side
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      pcc_sel_e   sel;
      logic [7:0] wdata;
   } pcc_acc_s;

   // Counter-side information shared by all channels
   typedef struct packed
   {
      logic [15:0] count;
      logic        tick;
      logic [1:0]  clen;
      logic        reload_sel;
   } pcc_cnt_s;

endpackage : pcc_pkg

// ### hw/pcc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-stage pin synchroniser with agreement filter
module pcc_pin_sync
   import pcc_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Pin and filtered level
   input  wire logic pin_async,
   output logic      level
);

   logic [SYNC_STAGES-1:0] sync_r;
   logic                   level_r;

   // Shift chain; stage 0 feeds only stage 1
   always_ff @(posedge mclk)
   begin
      if (rst)
         sync_r <= '0;
      else
         sync_r <= {sync_r[SYNC_STAGES-2:0], pin_async};
   end

   // Level changes once stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (rst)
         level_r <= 1'b0;
      else if (sync_r[1] == sync_r[2])
         level_r <= sync_r[2];
   end

   assign level = level_r;

endmodule : pcc_pin_sync

`default_nettype wire

// ### hw/pcc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module pcc_channel
   import pcc_pkg::*;
(
   // Clock and reset
   input  wire logic     mclk,
   input  wire logic     rst,
   // Register access
   input  wire pcc_acc_s acc,
   output logic [7:0]    rdata,
   // Shared counter
   input  wire pcc_cnt_s cnt,
   // Flags
   input  wire logic     flag_clr,
   output logic          channel_event_flag,
   output logic          channel_irq,
   output logic          mid_overflow_flag,
   input  wire logic     mid_flag_clr,
   input  wire logic     mid_overflow_irq_enable,
   output logic          mid_irq,
   // Pin
   input  wire logic     channel_pin_in,
   output logic          channel_pin_out,
   output logic          channel_pin_oe_n,
   output logic          channel_pin_level
);

   // =======================================================
   // State
   logic [7:0]  mode_r;
   logic [15:0] value_r;
   logic [15:0] reload_r;
   logic        flag_r;
   logic        irq_r;
   logic        mid_r;
   logic        mid_irq_r;
   logic        pin_r;
   logic        oe_n_r;
   logic [7:0]  rdata_r;
   logic        lvl_r;
   logic        lvl_prev_r;
   logic        sync_level;
   pcc_mode_e   mode;

   // Synchronised pin
   pcc_pin_sync u_sync
   (
      .mclk      (mclk),
      .rst       (rst),
      .pin_async (channel_pin_in),
      .level     (sync_level)
   );

   // =======================================================
   // Mode decode
   function automatic pcc_mode_e decode_mode(input logic [7:0] m);
      pcc_mode_e d;
      d = PCC_M_IDLE;
      if (m[MODE_PULSE_BIT] | m[MODE_TOGGLE_BIT] | m[MODE_MATCH_BIT])
      begin
         if (m[MODE_RISE_BIT] | m[MODE_FALL_BIT])
            d = PCC_M_IDLE;
         else if (m[MODE_TOGGLE_BIT] & m[MODE_PULSE_BIT])
            d = PCC_M_FREQ;
         else if (m[MODE_TOGGLE_BIT] & m[MODE_MATCH_BIT])
            d = PCC_M_TOGGLE;
         else if (m[MODE_PULSE_BIT] & ~m[MODE_TOGGLE_BIT])
            d = m[MODE_WIDE_BIT] ? PCC_M_PWM_16 : PCC_M_PWM_N;
         else if (m[MODE_MATCH_BIT] & ~m[MODE_TOGGLE_BIT])
            d = PCC_M_TIMER;
      end
      else if (m[MODE_RISE_BIT] | m[MODE_FALL_BIT])
         d = PCC_M_CAPTURE;
      return d;
   endfunction : decode_mode

   // Mask of active low bits for the shared cycle length
   function automatic logic [15:0] len_mask(input logic [1:0] c);
      return (16'h0001 << (5'd8 + {3'b000, c})) - 16'h0001;
   endfunction : len_mask

   assign mode = decode_mode(mode_r);

   // =======================================================
   // Comparison and overflow
   logic [15:0] mask;
   logic        cmp_on;
   logic        eq16;
   logic        eq_n;
   logic        eq_lo;
   logic        ovf_n;
   logic        ovf16;
   logic        rise_e;
   logic        fall_e;
   logic        cap_hit;
   logic        match_hit;
   logic        set_flag;
   logic [15:0] next_cnt;

   assign mask     = len_mask(cnt.clen);
   assign next_cnt = cnt.count + 16'h0001;
   assign cmp_on   = mode_r[MODE_CMP_EN_BIT];
   assign eq16     = cnt.tick & (cnt.count == value_r);
   assign eq_n     = cnt.tick & ((cnt.count & mask) == (value_r & mask));
   assign eq_lo    = cnt.tick & (cnt.count[7:0] == value_r[7:0]);
   assign ovf_n    = cnt.tick & ((next_cnt & mask) == 16'h0000);
   assign ovf16    = cnt.tick & (cnt.count == 16'hFFFF);
   assign rise_e   = lvl_r & ~lvl_prev_r;
   assign fall_e   = ~lvl_r & lvl_prev_r;
   assign cap_hit  = (mode == PCC_M_CAPTURE)
                   & ((rise_e & mode_r[MODE_RISE_BIT])
                   | (fall_e & mode_r[MODE_FALL_BIT]));

   // Match event per mode, comparator gated by compare enable
   always_comb
   begin
      match_hit = 1'b0;
      unique case (mode)
         PCC_M_TIMER,
         PCC_M_TOGGLE,
         PCC_M_PWM_16: match_hit = cmp_on & eq16;
         PCC_M_PWM_N:  match_hit = cmp_on & eq_n;
         PCC_M_FREQ:   match_hit = cmp_on & eq16;
         PCC_M_IDLE,
         PCC_M_CAPTURE: match_hit = 1'b0;
      endcase
   end

   assign set_flag = cap_hit
                   | (match_hit & mode_r[MODE_MATCH_BIT]);

   // =======================================================
   // Edge detector state
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lvl_r      <= 1'b0;
         lvl_prev_r <= 1'b0;
      end
      else
      begin
         lvl_r      <= sync_level;
         lvl_prev_r <= lvl_r;
      end
   end

   // =======================================================
   // Mode register, with compare-enable side effects
   always_ff @(posedge mclk)
   begin
      if (rst)
         mode_r <= MODE_RESET;
      else if (acc.wr & (acc.sel == PCC_SEL_MODE))
         mode_r <= acc.wdata;
      else if (acc.wr & ~cnt.reload_sel & (acc.sel == PCC_SEL_LOW))
         mode_r[MODE_CMP_EN_BIT] <= 1'b0;
      else if (acc.wr & ~cnt.reload_sel & (acc.sel == PCC_SEL_HIGH))
         mode_r[MODE_CMP_EN_BIT] <= 1'b1;
   end

   // =======================================================
   // Capture/compare value and auto-reload value
   always_ff @(posedge mclk)
   begin
      if (rst)
         value_r <= VALUE_RESET;
      else if (cap_hit)
         value_r <= cnt.count;
      else if (acc.wr & ~cnt.reload_sel & (acc.sel == PCC_SEL_LOW))
         value_r[7:0] <= acc.wdata;
      else if (acc.wr & ~cnt.reload_sel & (acc.sel == PCC_SEL_HIGH))
         value_r[15:8] <= acc.wdata;
      else if ((mode == PCC_M_FREQ) & cmp_on & eq_lo)
         value_r[7:0] <= value_r[7:0] + value_r[15:8];
      else if ((mode == PCC_M_PWM_N) & ovf_n)
         value_r <= (cnt.clen == 2'b00)
                  ? {value_r[15:8], value_r[15:8]} : reload_r;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         reload_r <= VALUE_RESET;
      else if (acc.wr & cnt.reload_sel & (acc.sel == PCC_SEL_LOW))
         reload_r[7:0] <= acc.wdata;
      else if (acc.wr & cnt.reload_sel & (acc.sel == PCC_SEL_HIGH))
         reload_r[15:8] <= acc.wdata;
   end

   // =======================================================
   // Read data
   always_ff @(posedge mclk)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (acc.rd)
      begin
         unique case (acc.sel)
            PCC_SEL_MODE: rdata_r <= mode_r;
            PCC_SEL_LOW:  rdata_r <= cnt.reload_sel ? reload_r[7:0]
                                                    : value_r[7:0];
            PCC_SEL_HIGH: rdata_r <= cnt.reload_sel ? reload_r[15:8]
                                                    : value_r[15:8];
            PCC_SEL_NONE: rdata_r <= 8'h00;
         endcase
      end
   end

   // =======================================================
   // Channel flag and interrupt; set wins over clear
   always_ff @(posedge mclk)
   begin
      if (rst)
         flag_r <= 1'b0;
      else if (set_flag)
         flag_r <= 1'b1;
      else if (flag_clr)
         flag_r <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= (flag_r | set_flag) & ~(flag_clr & ~set_flag)
                & mode_r[MODE_IRQ_EN_BIT];
   end

   // Mid overflow flag and its interrupt
   always_ff @(posedge mclk)
   begin
      if (rst)
         mid_r <= 1'b0;
      else if (ovf_n)
         mid_r <= 1'b1;
      else if (mid_flag_clr)
         mid_r <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         mid_irq_r <= 1'b0;
      else
         mid_irq_r <= (mid_r | ovf_n) & ~(mid_flag_clr & ~ovf_n)
                    & mid_overflow_irq_enable;
   end

   // =======================================================
   // Pin output drive
   always_ff @(posedge mclk)
   begin
      if (rst)
         pin_r <= 1'b0;
      else
      begin
         unique case (mode)
            PCC_M_TOGGLE,
            PCC_M_FREQ:
               if (mode == PCC_M_FREQ ? (cmp_on & eq_lo) : match_hit)
                  pin_r <= ~pin_r;
            PCC_M_PWM_N:
               if (~cmp_on)
                  pin_r <= 1'b0;
               else if (ovf_n)
                  pin_r <= 1'b0;
               else if (match_hit)
                  pin_r <= 1'b1;
            PCC_M_PWM_16:
               if (~cmp_on | ovf16)
                  pin_r <= 1'b0;
               else if (match_hit)
                  pin_r <= 1'b1;
            PCC_M_IDLE, PCC_M_TIMER,
            PCC_M_CAPTURE:
               pin_r <= pin_r;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         oe_n_r <= 1'b1;
      else
         oe_n_r <= ~((mode == PCC_M_TOGGLE) | (mode == PCC_M_FREQ)
                   | (mode == PCC_M_PWM_N) | (mode == PCC_M_PWM_16));
   end

   // =======================================================
   // Outputs
   assign rdata              = rdata_r;
   assign channel_event_flag = flag_r;
   assign channel_irq        = irq_r;
   assign mid_overflow_flag  = mid_r;
   assign mid_irq            = mid_irq_r;
   assign channel_pin_out    = pin_r;
   assign channel_pin_oe_n   = oe_n_r;
   assign channel_pin_level  = lvl_r;

   // =======================================================
   // Checks
   AST_CAPTURE_FLAG: assert property (@(posedge mclk) disable iff (rst)
      cap_hit |=> flag_r) else $error("capture did not set flag");
   AST_CAPTURE_VAL: assert property (@(posedge mclk) disable iff (rst)
      cap_hit |=> value_r == $past(cnt.count))
      else $error("capture value wrong");
   AST_LOW_CLEARS: assert property (@(posedge mclk) disable iff (rst)
      acc.wr & ~cnt.reload_sel & acc.sel == PCC_SEL_LOW
      |=> ~mode_r[MODE_CMP_EN_BIT]) else $error("low write kept cmp");
   AST_HIGH_SETS: assert property (@(posedge mclk) disable iff (rst)
      acc.wr & ~cnt.reload_sel & acc.sel == PCC_SEL_HIGH
      |=> mode_r[MODE_CMP_EN_BIT]) else $error("high write no cmp");
   AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (rst)
      flag_r & ~flag_clr |=> flag_r) else $error("flag lost");
   AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
      ##1 irq_r == (flag_r & $past(mode_r[MODE_IRQ_EN_BIT])))
      else $error("irq mismatch");
   AST_TIMER: assert property (@(posedge mclk) disable iff (rst)
      mode == PCC_M_TIMER & cmp_on & eq16 |=> flag_r)
      else $error("timer match missed");
   AST_PWM_OFF: assert property (@(posedge mclk) disable iff (rst)
      (mode == PCC_M_PWM_N | mode == PCC_M_PWM_16) & ~cmp_on |=> ~pin_r)
      else $error("pwm not zero");
   AST_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
      mode == PCC_M_TOGGLE & match_hit |=> pin_r != $past(pin_r))
      else $error("no toggle");
   AST_MID: assert property (@(posedge mclk) disable iff (rst)
      ovf_n |=> mid_r) else $error("mid flag missed");

   CV_CAPTURE: cover property (@(posedge mclk) disable iff (rst) cap_hit);
   CV_TIMER: cover property (@(posedge mclk) disable iff (rst)
      mode == PCC_M_TIMER & match_hit);
   CV_PWM: cover property (@(posedge mclk) disable iff (rst)
      mode == PCC_M_PWM_N & match_hit);

endmodule : pcc_channel

`default_nettype wire

// ### sim/pcc_pin_source.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Signal source on the channel pin
module pcc_pin_source
(
   // Clock
   input  wire logic mclk,
   // Requested level and pin
   input  wire logic want,
   output logic      pin
);
   logic [1:0] held_r;

   initial
   begin
      pin    = 1'b0;
      held_r = 2'h0;
   end

   // Move to a new level only after two stable clocks
   always @(posedge mclk)
   begin
      if (want != pin && held_r >= 2'h2)
      begin
         pin    <= want;
         held_r <= 2'h0;
      end
      else if (held_r != 2'h3)
      begin
         held_r <= held_r + 2'h1;
      end
   end
endmodule : pcc_pin_source
`default_nettype wire

// ### sim/counter_array_capture_compare_channel_test.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Testbench top
module counter_array_capture_compare_channel_test
   import pcc_pkg::*;
;
   logic       mclk;
   logic       rst;
   pcc_acc_s   acc;
   pcc_cnt_s   cnt;
   logic       flag_clr;
   logic [7:0] rdata;
   logic       flag;
   logic       irq;
   logic       pin_out;
   logic       pin_oe_n;
   logic       pin_level;
   logic       mid_flag;
   logic       mid_clr;
   logic       mid_ien;
   logic       mid_irq;
   logic       src_pin;
   logic       want;
   logic       pin_wire;
   logic [15:0] exp_val;
   int         bad_count;
   int         tests_run;

   // Wire level: design drives when enabled, else the source
   assign pin_wire = pin_oe_n ? src_pin : pin_out;

   pcc_channel dut_u
   (
      .mclk                    (mclk),
      .rst                     (rst),
      .acc                     (acc),
      .rdata                   (rdata),
      .cnt                     (cnt),
      .flag_clr                (flag_clr),
      .channel_event_flag      (flag),
      .channel_irq             (irq),
      .mid_overflow_flag       (mid_flag),
      .mid_flag_clr            (mid_clr),
      .mid_overflow_irq_enable (mid_ien),
      .mid_irq                 (mid_irq),
      .channel_pin_in          (pin_wire),
      .channel_pin_out         (pin_out),
      .channel_pin_oe_n        (pin_oe_n),
      .channel_pin_level       (pin_level)
   );

   pcc_pin_source src_u
   (
      .mclk (mclk),
      .want (want),
      .pin  (src_pin)
   );

   // Clock, 8 ns period
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   // One register access, answer sampled two cycles after the request
   task automatic access(input logic w, input pcc_sel_e s,
                         input logic [7:0] d, output logic [7:0] q);
      @(negedge mclk);
      acc.wr    = w;
      acc.rd    = ~w;
      acc.sel   = s;
      acc.wdata = d;
      @(negedge mclk);
      acc.wr = 1'b0;
      acc.rd = 1'b0;
      @(negedge mclk);
      q = rdata;
   endtask : access

   task automatic wr(input pcc_sel_e s, input logic [7:0] d);
      logic [7:0] q;
      access(1'b1, s, d, q);
   endtask : wr

   task automatic rd_chk(input pcc_sel_e s, input logic [7:0] e);
      logic [7:0] q;
      access(1'b0, s, 8'h00, q);
      check({8'h00, q}, {8'h00, e});
   endtask : rd_chk

   // Wait for the flag under a bound
   task automatic wait_flag();
      for (int i = 0; i < 12 && flag !== 1'b1; i++)
         @(negedge mclk);
   endtask : wait_flag

   // One counter step with tick raised
   task automatic tick_at(input logic [15:0] c);
      cnt.count = c;
      cnt.tick  = 1'b1;
      @(negedge mclk);
      cnt.tick  = 1'b0;
   endtask : tick_at

   task automatic clear_flag();
      @(negedge mclk);
      flag_clr = 1'b1;
      @(negedge mclk);
      flag_clr = 1'b0;
      repeat (2) @(negedge mclk);
      check(flag, 1'b0);
   endtask : clear_flag

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check({flag, irq, pin_out, pin_oe_n, mid_flag, mid_irq, pin_level},
            7'h08);
      rd_chk(PCC_SEL_MODE, MODE_RESET);
   endtask : t_reset

   task automatic t_regs();
      wr(PCC_SEL_MODE, 8'h48);
      rd_chk(PCC_SEL_MODE, 8'h48);
      wr(PCC_SEL_LOW, 8'h34);
      rd_chk(PCC_SEL_MODE, 8'h08);
      wr(PCC_SEL_HIGH, 8'h12);
      rd_chk(PCC_SEL_MODE, 8'h48);
      rd_chk(PCC_SEL_LOW, 8'h34);
      rd_chk(PCC_SEL_HIGH, 8'h12);
      rd_chk(PCC_SEL_NONE, 8'h00);
   endtask : t_regs

   task automatic t_timer();
      wr(PCC_SEL_MODE, 8'h49);
      @(negedge mclk);
      cnt.count = 16'h1233;
      cnt.tick  = 1'b1;
      repeat (3) @(negedge mclk);
      check(flag, 1'b0);
      cnt.count = 16'h1234;
      @(negedge mclk);
      cnt.tick = 1'b0;
      wait_flag();
      check(flag, 1'b1);
      repeat (6) @(negedge mclk);
      check({flag, irq}, 2'h3);
      clear_flag();
      @(negedge mclk);
      check(irq, 1'b0);
      exp_val = 16'h1234;
   endtask : t_timer

   // One edge in capture mode
   task automatic edge_case(input logic lvl, input logic hit,
                            input logic [15:0] c);
      cnt.count = c;
      want      = lvl;
      wait_flag();
      repeat (2) @(negedge mclk);
      check(flag, hit);
      check(irq, hit);
      check(pin_level, lvl);
      if (hit)
         exp_val = c;
      rd_chk(PCC_SEL_LOW, exp_val[7:0]);
      rd_chk(PCC_SEL_HIGH, exp_val[15:8]);
      if (hit)
         clear_flag();
   endtask : edge_case

   task automatic t_capture(input logic [7:0] m, input logic r,
                            input logic f);
      wr(PCC_SEL_MODE, m);
      edge_case(1'b1, r, 16'hA5C3);
      edge_case(1'b0, f, 16'h5A3C);
   endtask : t_capture

   // Toggle on match, frozen with compare off
   task automatic t_toggle();
      wr(PCC_SEL_MODE, 8'h4D);
      wr(PCC_SEL_LOW, 8'h00);
      wr(PCC_SEL_HIGH, 8'h20);
      check({pin_oe_n, pin_out}, 2'h0);
      tick_at(16'h2000);
      check({pin_out, flag, irq}, 3'h7);
      clear_flag();
      wr(PCC_SEL_LOW, 8'h00);
      tick_at(16'h2000);
      check({pin_out, flag}, 2'h2);
   endtask : t_toggle

   // Square wave stepped by the high byte, zero adding no step
   task automatic t_freq();
      wr(PCC_SEL_MODE, 8'h46);
      wr(PCC_SEL_LOW, 8'h10);
      wr(PCC_SEL_HIGH, 8'h03);
      tick_at(16'h0010);
      check({pin_out, flag}, 2'h0);
      rd_chk(PCC_SEL_LOW, 8'h13);
      tick_at(16'h0013);
      check(pin_out, 1'b1);
      wr(PCC_SEL_HIGH, 8'h00);
      tick_at(16'h0016);
      check(pin_out, 1'b0);
      rd_chk(PCC_SEL_LOW, 8'h16);
   endtask : t_freq

   // Pulse modes of eight, nine and sixteen bits
   task automatic t_pwm();
      wr(PCC_SEL_MODE, 8'h4A);
      wr(PCC_SEL_LOW, 8'h80);
      wr(PCC_SEL_HIGH, 8'h40);
      tick_at(16'h0080);
      check({pin_out, flag}, 2'h3);
      tick_at(16'h00FF);
      check({pin_out, mid_flag, mid_irq}, 3'h3);
      rd_chk(PCC_SEL_LOW, 8'h40);
      clear_flag();
      mid_clr = 1'b1;
      @(negedge mclk);
      mid_clr = 1'b0;
      check({mid_flag, mid_irq}, 2'h0);
      tick_at(16'h0040);
      check(pin_out, 1'b1);
      wr(PCC_SEL_LOW, 8'h40);
      check(pin_out, 1'b0);
      cnt.clen       = 2'b01;
      cnt.reload_sel = 1'b1;
      wr(PCC_SEL_LOW, 8'h23);
      wr(PCC_SEL_HIGH, 8'h01);
      rd_chk(PCC_SEL_LOW, 8'h23);
      cnt.reload_sel = 1'b0;
      wr(PCC_SEL_HIGH, 8'h00);
      tick_at(16'h00FF);
      check(mid_flag, 1'b0);
      tick_at(16'h0040);
      check(pin_out, 1'b1);
      tick_at(16'h01FF);
      check({pin_out, mid_flag}, 2'h1);
      rd_chk(PCC_SEL_HIGH, 8'h01);
      wr(PCC_SEL_MODE, 8'hCA);
      tick_at(16'h0023);
      check(pin_out, 1'b0);
      tick_at(16'h0123);
      check(pin_out, 1'b1);
      tick_at(16'h01FF);
      check(pin_out, 1'b1);
      tick_at(16'hFFFF);
      check(pin_out, 1'b0);
   endtask : t_pwm

   // ==========================================================
   // Verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // Main sequence
   initial
   begin
      bad_count = 0;
      tests_run = 0;
      rst       = 1'b1;
      acc       = '0;
      cnt       = '0;
      flag_clr  = 1'b0;
      mid_clr   = 1'b0;
      mid_ien   = 1'b1;
      want      = 1'b0;
      exp_val   = VALUE_RESET;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_reset();
      t_regs();
      t_timer();
      t_capture(8'h21, 1'b1, 1'b0);
      t_capture(8'h11, 1'b0, 1'b1);
      t_capture(8'h31, 1'b1, 1'b1);
      t_toggle();
      t_freq();
      t_pwm();
      finish_test();
   end

   // Watchdog
   initial
   begin
      repeat (4000) @(posedge mclk);
      bad_count++;
      finish_test();
   end
endmodule : counter_array_capture_compare_channel_test
`default_nettype wire
